/* File: qwc_pkg.sv */
// Constants, register map and carrier types of the four-wire command framing host
package qwc_pkg;
  // Software register byte offsets
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_ADDR = 5'h04;
  localparam logic [4:0] REG_LEN  = 5'h08;
  localparam logic [4:0] REG_TXD  = 5'h0c;
  localparam logic [4:0] REG_RXD  = 5'h10;
  localparam logic [4:0] REG_STAT = 5'h14;
  localparam logic [4:0] REG_PARM = 5'h18;
  // Control word field positions
  localparam int CTL_OP_LSB   = 0;
  localparam int CTL_HAS_ADDR = 8;
  localparam int CTL_RX       = 9;
  localparam int CTL_TX       = 10;
  localparam int CTL_DUMMY    = 11;
  localparam int CTL_HAS_MODE = 12;
  localparam int CTL_AL_LSB   = 13;
  localparam int CTL_MODE_LSB = 16;
  // Alignment demands carried in the control word
  localparam logic [1:0] AL_WORD  = 2'h1;
  localparam logic [1:0] AL_OCTAL = 2'h2;
  // Status word bit positions
  localparam int STA_BUSY = 0;
  localparam int STA_TXF  = 1;
  localparam int STA_RXF  = 2;
  localparam int STA_ERR  = 3;
  localparam int STA_WEL  = 4;
  localparam int STA_VOL  = 5;
  // Opcodes
  localparam logic [7:0] OP_WREN   = 8'h06;
  localparam logic [7:0] OP_VWREN  = 8'h50;
  localparam logic [7:0] OP_WRDI   = 8'h04;
  localparam logic [7:0] OP_SUSP   = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_SETPRM = 8'hc0;
  localparam logic [7:0] OP_RDPDID = 8'hab;
  localparam logic [7:0] OP_WRAPRD = 8'h0c;
  localparam logic [7:0] OP_PP     = 8'h02;
  localparam logic [7:0] OP_SECPRG = 8'h42;
  localparam logic [7:0] OP_SECERA = 8'h44;
  localparam logic [7:0] OP_WSR1   = 8'h01;
  localparam logic [7:0] OP_WSR2   = 8'h31;
  localparam logic [7:0] OP_WSR3   = 8'h11;
  localparam logic [7:0] OP_SE     = 8'h20;
  localparam logic [7:0] OP_BE32   = 8'h52;
  localparam logic [7:0] OP_BE64   = 8'hd8;
  localparam logic [7:0] OP_CE_A   = 8'hc7;
  localparam logic [7:0] OP_CE_B   = 8'h60;
  localparam logic [7:0] OP_RST    = 8'h99;
  // Page size limit for program data
  localparam logic [8:0] PAGE_BYTES = 9'h100;
  // Nibble counts of header fields, two clocks per byte
  localparam logic [5:0] NIB_OP   = 6'h02;
  localparam logic [5:0] NIB_ADR  = 6'h06;
  localparam logic [5:0] NIB_MODE = 6'h02;
  // Reset values
  localparam logic [7:0] PARM_RST = 8'h00;
  // Link clock timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int SCLK_HALF_NS  = 160;
  localparam logic [2:0] SCLK_HALF_CYC = 3'(SCLK_HALF_NS / CLK_PERIOD_NS);
  // Pins toward the flash
  typedef struct packed {
    logic       cs_b;
    logic       sclk;
    logic [3:0] io_out;
    logic [3:0] io_oe;
  } qwc_link_t;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HDR  = 3'b001,
    ST_DMY  = 3'b010,
    ST_DAT  = 3'b011,
    ST_END  = 3'b100
  } qwc_state_t;
endpackage : qwc_pkg

/* File: qwc_host.sv */
// Host controller framing four-wire command mode instructions toward a serial flash
//
// Overview of operation
// (RL1) Every byte moves on four lines, two clocks
// (RL2) Bytes go most significant bit first
// (RL3) Status and identifier repeat until chip select rises
// (RL4) Program data is one to 256 bytes
// (RL5) Security registers sit at 00h, 10h/20h/30h pages
// (RL6) Parameter upper nibble sets read dummy clocks
// (RL7) Parameter lower nibble sets burst wrap length
// (RL8) 50h, 06h, 04h are single-byte instructions
// (RL9) 75h suspends, 7Ah resumes, single byte each
// (RL10) ABh, three dummy bytes, then identifier out
// (RL11) 0Ch, three address bytes, dummies, data stream
// (RL12) IO3..IO0 carry bits 7..4 then 3..0
// (RL13) Quad address: top bit of nibble on IO3
// (RL14) Dual address: odd bits IO1, even IO0
// (RL15) Word quad read address has bit 0 clear
// (RL16) Octal word read address low nibble clear
// (RL17) 06h sets latch; writes need latch set
// (RL18) Select low, shift opcode, select high completes
// (RL19) Latch clears after program, erase, status write
// (RL20) Mode needs lane enable bit; bit locked then
// (RL21) Unknown opcode ignored until select cycles again
`timescale 1ns/10ps
module qwc_host (
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  input  wire logic [4:0]        reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic [31:0]            reg_rdata_o,
  input  wire logic [3:0]        io_in_i,
  output qwc_pkg::qwc_link_t     link_o
);

  // Security register pages, upper and middle address bytes
  function automatic logic is_sec_addr(input logic [23:0] a);
    is_sec_addr = (a[23:16] == 8'h00) && (a[15:8] == 8'h10 || a[15:8] == 8'h20 || a[15:8] == 8'h30); // RL5
  endfunction : is_sec_addr

  // Instructions that demand the latch and clear it when done
  function automatic logic needs_wel(input logic [7:0] op);
    needs_wel = op == qwc_pkg::OP_PP || op == qwc_pkg::OP_SECPRG || op == qwc_pkg::OP_SECERA ||
                op == qwc_pkg::OP_WSR1 || op == qwc_pkg::OP_WSR2 || op == qwc_pkg::OP_WSR3 ||
                op == qwc_pkg::OP_SE || op == qwc_pkg::OP_BE32 || op == qwc_pkg::OP_BE64 ||
                op == qwc_pkg::OP_CE_A || op == qwc_pkg::OP_CE_B;
  endfunction : needs_wel

  // Status register writes, allowed after a volatile enable too
  function automatic logic is_wsr(input logic [7:0] op);
    is_wsr = op == qwc_pkg::OP_WSR1 || op == qwc_pkg::OP_WSR2 || op == qwc_pkg::OP_WSR3;
  endfunction : is_wsr

  qwc_pkg::qwc_state_t st;        // Sequencer state
  qwc_pkg::qwc_link_t  link;      // Pin drive, straight to the port
  logic [23:0]         ctrl;      // Control word of the running instruction
  logic [23:0]         addr;      // Flash address
  logic [8:0]          len;       // Data bytes to move
  logic [8:0]          cnt;       // Data bytes left
  logic [7:0]          tx_byte;   // Byte waiting to go out
  logic                tx_full;   // Transmit holding byte valid
  logic [7:0]          rx_byte;   // Last received byte
  logic                rx_full;   // Receive holding byte valid
  logic [7:0]          parm;      // Shadow of the read parameter byte
  logic                write_enable_latch;       // Shadow of the write enable latch
  logic                vol;       // Volatile status write enabled
  logic                err;       // Sticky refusal flag
  logic [2:0]          div;       // Half period counter
  logic [39:0]         sh;        // Header and data shifter
  logic [5:0]          nib;       // Nibbles or clocks left in phase
  logic                hi;        // Next data nibble is the upper one
  logic                need;      // Waiting for a byte slot
  logic [3:0]          io_s1;     // Input synchroniser stages
  logic [3:0]          io_s2;
  logic [3:0]          io_s3;
  logic [3:0]          io_q;      // Debounced input nibble
  logic [31:0]         rdata;     // Read data flop

  // Register port decode
  wire       wr_ctrl  = reg_wr_i && reg_addr_i == qwc_pkg::REG_CTRL;
  wire       wr_addr  = reg_wr_i && reg_addr_i == qwc_pkg::REG_ADDR;
  wire       wr_len   = reg_wr_i && reg_addr_i == qwc_pkg::REG_LEN;
  wire       wr_txd   = reg_wr_i && reg_addr_i == qwc_pkg::REG_TXD && !tx_full;
  wire       wr_stat  = reg_wr_i && reg_addr_i == qwc_pkg::REG_STAT;
  wire       rd_rxd   = reg_rd_i && reg_addr_i == qwc_pkg::REG_RXD;
  wire       busy     = st != qwc_pkg::ST_IDLE;
  wire [7:0] new_op   = reg_wdata_i[qwc_pkg::CTL_OP_LSB +: 8];
  wire [1:0] new_al   = reg_wdata_i[qwc_pkg::CTL_AL_LSB +: 2];
  wire       new_data = reg_wdata_i[qwc_pkg::CTL_RX] || reg_wdata_i[qwc_pkg::CTL_TX];

  // Refusal causes for a new instruction
  wire bad_len = (new_op == qwc_pkg::OP_PP || new_op == qwc_pkg::OP_SECPRG) &&
                 (len == 9'h000 || len > qwc_pkg::PAGE_BYTES); // RL4
  wire bad_al  = (new_al == qwc_pkg::AL_WORD && addr[0]) ||                  // RL15
                 (new_al == qwc_pkg::AL_OCTAL && addr[3:0] != 4'h0);         // RL16
  wire bad_wel = needs_wel(new_op) && !write_enable_latch && !(vol && is_wsr(new_op));       // RL17
  wire bad_sec = (new_op == qwc_pkg::OP_SECPRG || new_op == qwc_pkg::OP_SECERA) && !is_sec_addr(addr);
  wire refuse  = wr_ctrl && (busy || bad_len || bad_al || bad_wel || bad_sec);
  wire accept  = wr_ctrl && !refuse;

  // Header nibble count: opcode, then optional address and mode byte
  wire [5:0] hdr_nib = qwc_pkg::NIB_OP +
                       (reg_wdata_i[qwc_pkg::CTL_HAS_ADDR] ? qwc_pkg::NIB_ADR : 6'h00) +
                       (reg_wdata_i[qwc_pkg::CTL_HAS_MODE] ? qwc_pkg::NIB_MODE : 6'h00);
  // Header image, opcode left-justified, mode after address
  // Address bytes double as the three dummy bytes of an identifier read
  wire [39:0] hdr_img = reg_wdata_i[qwc_pkg::CTL_HAS_ADDR] ? // RL10
                        {new_op, addr, reg_wdata_i[qwc_pkg::CTL_MODE_LSB +: 8]} :
                        {new_op, reg_wdata_i[qwc_pkg::CTL_MODE_LSB +: 8], 24'h000000};

  // Link timing strobes
  wire       tick     = div == qwc_pkg::SCLK_HALF_CYC - 3'h1;
  wire       rise     = tick && !link.sclk;
  wire       fall     = tick && link.sclk;
  wire       last     = nib == 6'h01;
  wire       dir_tx   = ctrl[qwc_pkg::CTL_TX];
  wire       dir_rx   = ctrl[qwc_pkg::CTL_RX];
  wire       has_data = dir_tx || dir_rx;
  wire [5:0] dmy_clk  = {2'h0, parm[7:4]}; // RL6
  wire       use_dmy  = ctrl[qwc_pkg::CTL_DUMMY] && dmy_clk != 6'h00;
  wire [7:0] cur_op   = ctrl[qwc_pkg::CTL_OP_LSB +: 8];
  // Byte slot ready: outgoing byte present, or room for an incoming one
  wire       slot_ok  = dir_tx ? tx_full : !rx_full;
  wire       tx_take  = st == qwc_pkg::ST_DAT && need && dir_tx && tx_full;
  wire       rx_put   = st == qwc_pkg::ST_DAT && fall && !hi && dir_rx;
  wire [7:0] rx_new   = {sh[3:0], io_q}; // RL2
  wire       done     = st == qwc_pkg::ST_END && tick;

  // Read multiplexer
  wire [31:0] stat_word = {26'h0, vol, write_enable_latch, err, rx_full, tx_full, busy};
  wire [31:0] rd_mux =
    reg_addr_i == qwc_pkg::REG_CTRL ? {8'h00, ctrl} :
    reg_addr_i == qwc_pkg::REG_ADDR ? {8'h00, addr} :
    reg_addr_i == qwc_pkg::REG_LEN  ? {23'h0, len} :
    reg_addr_i == qwc_pkg::REG_TXD  ? {24'h0, tx_byte} :
    reg_addr_i == qwc_pkg::REG_RXD  ? {24'h0, rx_byte} :
    reg_addr_i == qwc_pkg::REG_STAT ? stat_word :
    reg_addr_i == qwc_pkg::REG_PARM ? {24'h0, parm} : 32'h0;

  // Pin inputs: three stages, a change counts once stages two and three agree
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      io_s1 <= 4'h0;
      io_s2 <= 4'h0;
      io_s3 <= 4'h0;
      io_q  <= 4'h0;
    end else begin
      io_s1 <= io_in_i;
      io_s2 <= io_s1;
      io_s3 <= io_s2;
      if (io_s2 == io_s3) begin
        io_q <= io_s3;
      end
    end
  end

  // Software-written setup registers and read data
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      addr  <= 24'h000000;
      len   <= 9'h000;
      rdata <= 32'h0;
    end else begin
      if (wr_addr) begin
        addr <= reg_wdata_i[23:0];
      end
      if (wr_len) begin
        len <= reg_wdata_i[8:0];
      end
      // Data stands only in the cycle after the read strobe
      rdata <= reg_rd_i ? rd_mux : 32'h0;
    end
  end

  // Holding bytes; the hardware set wins over a software clear
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_byte <= 8'h00;
      tx_full <= 1'b0;
      rx_byte <= 8'h00;
      rx_full <= 1'b0;
      err     <= 1'b0;
    end else begin
      if (wr_txd) begin
        tx_byte <= reg_wdata_i[7:0];
      end
      tx_full <= wr_txd || (tx_full && !tx_take);
      if (rx_put) begin
        rx_byte <= rx_new;
      end
      rx_full <= rx_put || (rx_full && !rd_rxd);
      err     <= refuse || (err && !(wr_stat && reg_wdata_i[qwc_pkg::STA_ERR]));
    end
  end

  // Latch shadows follow completed instructions; the parameter shadow loads when its data byte is taken
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      write_enable_latch  <= 1'b0;
      vol  <= 1'b0;
      parm <= qwc_pkg::PARM_RST;
    end else begin
      if (tx_take && cur_op == qwc_pkg::OP_SETPRM) begin
        parm <= tx_byte; // RL6 RL7
      end
      if (done) begin
        if (cur_op == qwc_pkg::OP_WREN) begin
          write_enable_latch <= 1'b1; // RL17
        end else if (cur_op == qwc_pkg::OP_WRDI || cur_op == qwc_pkg::OP_RST || needs_wel(cur_op)) begin
          write_enable_latch <= 1'b0; // RL19
        end
        vol <= cur_op == qwc_pkg::OP_VWREN; // RL8
      end
    end
  end

  // Sequencer: opcode, address, mode, dummies, data, then select high
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st   <= qwc_pkg::ST_IDLE;
      link <= '{cs_b: 1'b1, sclk: 1'b0, io_out: 4'h0, io_oe: 4'h0};
      ctrl <= 24'h000000;
      sh   <= 40'h0;
      nib  <= 6'h00;
      cnt  <= 9'h000;
      div  <= 3'h0;
      hi   <= 1'b1;
      need <= 1'b0;
    end else begin
      div <= tick ? 3'h0 : div + 3'h1;
      unique case (st)
        qwc_pkg::ST_IDLE: begin
          div <= 3'h0;
          // Select falls with the first nibble already on the lines
          if (accept) begin
            st          <= qwc_pkg::ST_HDR;
            ctrl        <= reg_wdata_i[23:0];
            sh          <= {hdr_img[35:0], 4'h0};
            nib         <= hdr_nib;
            cnt         <= new_data ? len : 9'h000;
            link.cs_b   <= 1'b0;                // RL18
            link.io_out <= new_op[7:4];         // RL12
            link.io_oe  <= 4'hf;                // RL1
          end
        end
        qwc_pkg::ST_HDR, qwc_pkg::ST_DMY: begin
          if (rise) begin
            link.sclk <= 1'b1;
          end else if (fall) begin
            link.sclk   <= 1'b0;
            nib         <= nib - 6'h01;
            link.io_out <= sh[39:36];           // RL13
            sh          <= {sh[35:0], 4'h0};
            if (last) begin
              // Header done: dummies, then data, else finish
              if (st == qwc_pkg::ST_HDR && use_dmy) begin
                st         <= qwc_pkg::ST_DMY;
                nib        <= dmy_clk;          // RL11
                link.io_oe <= 4'h0;
              end else if (has_data && cnt != 9'h000) begin
                st         <= qwc_pkg::ST_DAT;
                need       <= 1'b1;
                hi         <= 1'b1;
                link.io_oe <= dir_tx ? 4'hf : 4'h0;
              end else begin
                st         <= qwc_pkg::ST_END;
                link.cs_b  <= 1'b1;             // RL18
                link.io_oe <= 4'h0;
              end
            end
          end
        end
        qwc_pkg::ST_DAT: begin
          if (need) begin
            // Clock held low until a byte slot is ready
            div <= 3'h0;
            if (slot_ok) begin
              need <= 1'b0;
              if (dir_tx) begin
                sh          <= {tx_byte[3:0], 36'h0};
                link.io_out <= tx_byte[7:4];    // RL12
              end
            end
          end else if (rise) begin
            link.sclk <= 1'b1;
          end else if (fall) begin
            link.sclk   <= 1'b0;
            hi          <= !hi;
            link.io_out <= sh[39:36];
            sh          <= {sh[35:0], io_q};    // RL2
            if (!hi) begin
              cnt <= cnt - 9'h001;
              // Repeated status bytes end only when select rises
              if (cnt == 9'h001) begin
                st         <= qwc_pkg::ST_END;  // RL3
                link.cs_b  <= 1'b1;
                link.io_oe <= 4'h0;
              end else begin
                need <= 1'b1;
              end
            end
          end
        end
        qwc_pkg::ST_END: begin
          // Select stays high one half period before the next instruction
          if (tick) begin
            st <= qwc_pkg::ST_IDLE;
          end
        end
        default: begin
          st <= qwc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign link_o      = link;
  assign reg_rdata_o = rdata;

endmodule : qwc_host

/* File: qwc_host_chk.sv */
// Checker of link framing and select timing for the host
`timescale 1ns/10ps
module qwc_host_chk (
  input wire logic               clk_i,
  input wire logic               rst_b_i,
  input wire logic [4:0]         reg_addr_i,
  input wire logic [31:0]        reg_wdata_i,
  input wire logic               reg_wr_i,
  input wire logic               reg_rd_i,
  input wire logic [31:0]        reg_rdata_o,
  input wire logic [3:0]         io_in_i,
  input wire qwc_pkg::qwc_link_t link_o
);
  logic [3:0] hi_cnt;  // Cycles with select high, saturating
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // Idle time, so a start request is known to be taken
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) hi_cnt <= 4'h0;
    else hi_cnt <= link_o.cs_b ? (hi_cnt == 4'hf ? hi_cnt : hi_cnt + 4'h1) : 4'h0;
  end
  // Start of a plain write enable while idle
  sequence wren_req;
    reg_wr_i && reg_addr_i == qwc_pkg::REG_CTRL && reg_wdata_i[15:0] == 16'h0006 && hi_cnt > 4'h6;
  endsequence
  // Two nibbles, then select released
  sequence wren_frame;
    !link_o.cs_b && link_o.io_oe == 4'hf && link_o.io_out == 4'h0 ##4 link_o.sclk
    ##4 !link_o.sclk && link_o.io_out == 4'h6 ##4 link_o.sclk ##4 link_o.cs_b;
  endsequence
  AST_WREN_FRAME: assert property (wren_req |=> wren_frame)
    else $error("write enable frame wrong");
  AST_CS_OE: assert property ($fell(link_o.cs_b) |-> link_o.io_oe == 4'hf)
    else $error("opcode not on four lines");
  AST_SCLK_HIGH: assert property ($rose(link_o.sclk) |-> link_o.sclk[*4] ##1 !link_o.sclk)
    else $error("clock high phase not four cycles");
  AST_IO_HOLD: assert property (link_o.sclk && $past(link_o.sclk) |-> $stable(link_o.io_out))
    else $error("data moved while clock high");
  AST_OUT_ON_FALL: assert property (!link_o.cs_b && !$past(link_o.cs_b) && link_o.io_oe != 4'h0
    && $changed(link_o.io_out) |-> !link_o.sclk) else $error("nibble changed while clock high");
  AST_CS_GAP: assert property ($rose(link_o.cs_b) |-> link_o.cs_b[*4])
    else $error("select high too short");
  AST_CS_SETUP: assert property ($fell(link_o.cs_b) |-> (!link_o.sclk)[*4])
    else $error("clock rose too soon after select");
  AST_CS_RELEASE: assert property (link_o.cs_b |-> !link_o.sclk && link_o.io_oe == 4'h0)
    else $error("link active with select high");
endmodule : qwc_host_chk
bind qwc_host qwc_host_chk chk_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .io_in_i(io_in_i), .link_o(link_o));

/* File: qwc_flash_mdl.sv */
// Behavioural flash device on the four-wire command link
`timescale 1ns/10ps
module qwc_flash_mdl #(
  parameter logic [7:0] ID_BYTE   = 8'h5a,  // Arbitrary identifier value
  parameter logic [7:0] WRAP_BYTE = 8'hc3   // Data of any burst read
) (
  input  wire qwc_pkg::qwc_link_t link_i,
  output logic [3:0]              io_o,
  output logic                    oe_o
);
  logic [7:0] log_q[$];  // Bytes taken in, all frames
  logic [7:0] op = 0;    // Opcode of this frame
  logic [7:0] sh = 0;    // Incoming shift register
  logic [7:0] parm = 0;  // Read parameters
  logic [7:0] dout;      // Byte repeated out
  logic       write_enable_latch = 0;   // Write enable latch
  int         nib = 0;   // Rising clock edges in this frame
  int         start;     // First output edge count
  initial oe_o = 1'b0;
  initial io_o = 4'h0;
  // New frame
  always @(negedge link_i.cs_b) begin
    nib = 0;
    op = 8'h00;
  end
  // Take a nibble on the rising edge, upper first; unknown codes do nothing
  always @(posedge link_i.sclk) if (!link_i.cs_b) begin
    sh = {sh[3:0], link_i.io_out};
    nib++;
    if (link_i.io_oe == 4'hf && nib % 2 == 0) begin
      log_q.push_back(sh);
      if (nib == 2) op = sh;
      if (nib == 4 && op == qwc_pkg::OP_SETPRM) parm = sh;
    end
  end
  // Drive after the fall; delay lets a rising select win the race
  always @(negedge link_i.sclk) begin
    #1;
    start = op == qwc_pkg::OP_RDPDID ? 8 : op == 8'h05 ? 2 :
            op == qwc_pkg::OP_WRAPRD ? 8 + int'(parm[7:4]) : 999;
    dout = op == 8'h05 ? {6'h00, write_enable_latch, 1'b0} : op == qwc_pkg::OP_RDPDID ? ID_BYTE : WRAP_BYTE;
    if (!link_i.cs_b && nib >= start) begin
      oe_o = 1'b1;
      io_o = nib[0] == start[0] ? dout[7:4] : dout[3:0];
    end
  end
  // Select high ends the frame and settles the latch
  always @(posedge link_i.cs_b) begin
    oe_o = 1'b0;
    if (op == qwc_pkg::OP_WREN) write_enable_latch = 1'b1;
    else if (op inside {qwc_pkg::OP_WRDI, qwc_pkg::OP_PP, qwc_pkg::OP_SECPRG, qwc_pkg::OP_SECERA,
      qwc_pkg::OP_WSR1, qwc_pkg::OP_WSR2, qwc_pkg::OP_WSR3, qwc_pkg::OP_SE, qwc_pkg::OP_BE32,
      qwc_pkg::OP_BE64, qwc_pkg::OP_CE_A, qwc_pkg::OP_CE_B, qwc_pkg::OP_RST}) write_enable_latch = 1'b0;
  end
endmodule : qwc_flash_mdl

/* File: tb_qwc_host.sv */
// Self-checking bench for the four-wire command framing host
`timescale 1ns/10ps
module tb_qwc_host;
  localparam logic [7:0] ID_BYTE = 8'h5a;  // Arbitrary identifier value
  logic               clk_i;            // 25 MHz clock
  logic               rst_b_i;          // Async reset, active low
  logic [4:0]         reg_addr;         // Register address
  logic [31:0]        reg_wdata;        // Write data
  logic               reg_wr;           // Write strobe
  logic               reg_rd;           // Read strobe
  logic [31:0]        reg_rdata;        // Read data
  qwc_pkg::qwc_link_t link;             // Pins toward the flash
  logic [3:0]         mdl_io;           // Device nibble
  logic               mdl_oe;           // Device drives
  logic [7:0]         cur_op;           // Opcode last started
  logic [31:0]        v;                // Scratch read value
  int                 n_fail = 0;       // Mismatches
  int                 comparisons = 0;  // Comparisons made
  int                 cyc = 0;          // Cycles run
  int                 base;             // Log size at start
  // Undriven lines show the inverse of the host's last value
  qwc_host dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .io_in_i(mdl_oe ? mdl_io : ~(link.io_oe ^ link.io_out)), .link_o(link));
  qwc_flash_mdl #(.ID_BYTE(ID_BYTE), .WRAP_BYTE(8'hc3)) mdl_u (.link_i(link), .io_o(mdl_io), .oe_o(mdl_oe));
  task automatic give_verdict;
    $display("counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_i);
    reg_wr <= 1'b0;
    @(posedge clk_i);
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_i);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk_i);
  endtask : rd
  // Bounded wait on one status bit
  task automatic poll(input int b, input logic val);
    for (int k = 0; k < 3000; k++) begin
      rd(qwc_pkg::REG_STAT, v);
      if (v[b] === val) return;
    end
    chk(v[b], val, "status wait");
  endtask : poll
  task automatic sbit(input int b, input logic e, input string what);
    rd(qwc_pkg::REG_STAT, v);
    chk(v[b], e, what);
  endtask : sbit
  task automatic go(input logic [7:0] op, input logic [7:0] fl, input logic [23:0] a, input logic [8:0] n);
    base = mdl_u.log_q.size();
    cur_op = op;
    wr(qwc_pkg::REG_ADDR, {8'h00, a});
    wr(qwc_pkg::REG_LEN, {23'h0, n});
    wr(qwc_pkg::REG_CTRL, {16'h0000, fl, op});
  endtask : go
  task automatic fin(input int n);
    poll(qwc_pkg::STA_BUSY, 1'b0);
    chk(32'(mdl_u.log_q.size() - base), 32'(n), "bytes on link");
    if (n > 0) chk({24'h0, mdl_u.log_q[base]}, {24'h0, cur_op}, "opcode");
  endtask : fin
  task automatic tx(input logic [7:0] d);
    poll(qwc_pkg::STA_TXF, 1'b0);
    wr(qwc_pkg::REG_TXD, {24'h0, d});
  endtask : tx
  task automatic rx(input logic [7:0] e, input string what);
    poll(qwc_pkg::STA_RXF, 1'b1);
    rd(qwc_pkg::REG_RXD, v);
    chk(v, {24'h0, e}, what);
  endtask : rx
  // A refused start sends nothing and flags the error
  task automatic refuse(input logic [7:0] op, input logic [7:0] fl, input logic [23:0] a, input logic [8:0] n);
    go(op, fl, a, n);
    fin(0);
    sbit(qwc_pkg::STA_ERR, 1'b1, "refusal flag");
    wr(qwc_pkg::REG_STAT, 32'h8);
  endtask : refuse
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // Ceiling well above the expected run length
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      give_verdict();
    end
  end
  initial begin
    rst_b_i = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    sbit(qwc_pkg::STA_WEL, 1'b0, "latch after reset");
    rd(qwc_pkg::REG_PARM, v);
    chk(v, {24'h0, qwc_pkg::PARM_RST}, "parameters after reset");
    rd(5'h1c, v);
    chk(v, 32'h0, "unmapped read");
    $display("test reset done");
    go(qwc_pkg::OP_WREN, 8'h00, 24'h0, 9'h0);
    fin(1);
    sbit(qwc_pkg::STA_WEL, 1'b1, "latch set");
    go(8'h05, 8'h02, 24'h0, 9'h002);
    rx(8'h02, "status");
    rx(8'h02, "status repeat");
    fin(1);
    go(qwc_pkg::OP_WRDI, 8'h00, 24'h0, 9'h0);
    fin(1);
    sbit(qwc_pkg::STA_WEL, 1'b0, "latch cleared");
    $display("test latch done");
    refuse(qwc_pkg::OP_PP, 8'h05, 24'h123400, 9'h001);
    go(qwc_pkg::OP_WREN, 8'h00, 24'h0, 9'h0);
    fin(1);
    refuse(qwc_pkg::OP_PP, 8'h05, 24'h123400, 9'h101);
    go(qwc_pkg::OP_PP, 8'h05, 24'h123400, 9'h100);
    for (int i = 0; i < 256; i++) tx(8'(i));
    fin(260);
    for (int i = 1; i < 260; i++)
      chk({24'h0, mdl_u.log_q[base + i]},
          {24'h0, i == 1 ? 8'h12 : i == 2 ? 8'h34 : i == 3 ? 8'h00 : 8'(i - 4)}, "byte");
    sbit(qwc_pkg::STA_WEL, 1'b0, "latch after program");
    $display("test program done");
    go(qwc_pkg::OP_SUSP, 8'h00, 24'h0, 9'h0);
    fin(1);
    go(qwc_pkg::OP_RESUME, 8'h00, 24'h0, 9'h0);
    fin(1);
    go(qwc_pkg::OP_VWREN, 8'h00, 24'h0, 9'h0);
    fin(1);
    sbit(qwc_pkg::STA_VOL, 1'b1, "volatile enable");
    $display("test single byte done");
    go(qwc_pkg::OP_RDPDID, 8'h03, 24'h0, 9'h002);
    rx(ID_BYTE, "identifier");
    rx(ID_BYTE, "identifier repeat");
    fin(4);
    $display("test identifier done");
    go(qwc_pkg::OP_SETPRM, 8'h04, 24'h0, 9'h001);
    tx(8'h21);
    fin(2);
    rd(qwc_pkg::REG_PARM, v);
    chk(v, 32'h21, "parameters");
    chk({24'h0, mdl_u.parm}, 32'h21, "device parameters");
    go(qwc_pkg::OP_WRAPRD, 8'h0b, 24'h00abcd, 9'h001);
    rx(8'hc3, "burst data");
    fin(4);
    $display("test burst done");
    go(qwc_pkg::OP_WREN, 8'h00, 24'h0, 9'h0);
    fin(1);
    refuse(qwc_pkg::OP_SECPRG, 8'h05, 24'h004000, 9'h001);
    refuse(8'heb, 8'h23, 24'h000001, 9'h001);
    refuse(8'heb, 8'h43, 24'h000008, 9'h001);
    go(qwc_pkg::OP_SECPRG, 8'h05, 24'h001005, 9'h001);
    tx(8'h77);
    fin(5);
    sbit(qwc_pkg::STA_ERR, 1'b0, "security accepted");
    $display("test refusals done");
    give_verdict();
  end
endmodule : tb_qwc_host
